// >>> inc/usb_ctrl_if.sv
// register port and sleep handshake between firmware end and device end
`timescale 1ns/10ps
`default_nettype none
interface usb_ctrl_if;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic sleep_req;
   usb_susp_pkg::sleep_mode_type sleep_mode;
   logic asleep;
   logic wake_irq;
   modport device_mp (
      input reg_addr, reg_wdata, reg_wr, reg_rd, sleep_req, sleep_mode,
      output reg_rdata, asleep, wake_irq
   );
   modport firmware_mp (
      output reg_addr, reg_wdata, reg_wr, reg_rd, sleep_req, sleep_mode,
      input reg_rdata, asleep, wake_irq
   );
endinterface
`default_nettype wire

// >>> inc/usb_susp_pkg.sv
// constants, types and register map of the usb suspend and line drive control
package usb_susp_pkg;
   // timing
   localparam int CLK_MHZ = 50;
   localparam int IDLE_TIME_US = 3000;
   localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
   localparam int POLL_TIME_US = 100;
   localparam int POLL_CYCLES = POLL_TIME_US * CLK_MHZ;
   localparam int RESUME_K_MIN_US = 1000;
   localparam int RESUME_K_MAX_US = 15000;
   localparam int RESUME_K_US = 2000;
   localparam int RESUME_K_CYCLES = RESUME_K_US * CLK_MHZ;
   // register offsets
   localparam logic [7:0] ADDR_BUS_CTRL2 = 8'h30;
   localparam logic [7:0] ADDR_FRAME_LO = 8'h31;
   localparam logic [7:0] ADDR_FRAME_HI = 8'h32;
   localparam logic [7:0] ADDR_ENABLE_ADDR = 8'h33;
   localparam logic [7:0] ADDR_LINE_DRIVE = 8'h34;
   // field positions
   localparam int REGMODE_BIT = 0;
   localparam int ACTIVITY_BIT = 1;
   localparam int ENABLE_BIT = 7;
   localparam int TX_ENABLE_BIT = 7;
   localparam int SE0_BIT = 6;
   localparam int JK_BIT = 5;
   localparam int RX_BIT = 0;
   localparam int ADDR_W = 7;
   localparam int FRAME_W = 11;
   // reset values
   localparam logic [7:0] BUS_CTRL2_RESET = 8'h00;
   localparam logic [7:0] ENABLE_ADDR_RESET = 8'h00;
   localparam logic [7:0] LINE_DRIVE_RESET = 8'h00;
   localparam logic [10:0] FRAME_RESET = 11'h000;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // firmware write values
   localparam logic [7:0] LINE_J = 8'hA0;
   localparam logic [7:0] LINE_K = 8'h80;
   localparam logic [7:0] LINE_RELEASE = 8'h00;
   localparam logic [7:0] ENABLE_ONLY = 8'h80;
   typedef enum logic [1:0] {
      SLEEP_STANDBY = 2'b00,
      SLEEP_RETAIN = 2'b01,
      SLEEP_DEEP = 2'b10
   } sleep_mode_type;
endpackage

// >>> test/usb_susp_chk.sv
// assertions on the control interface between firmware end and device end
`timescale 1ns/10ps
`default_nettype none
module usb_susp_chk #(
   parameter int RESUME_K_CYCLES = 30
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sleep_req,
   input wire usb_susp_pkg::sleep_mode_type sleep_mode,
   input wire logic asleep,
   input wire logic wake_irq
);
   // release may trail the K phase by up to three cycles
   localparam int K_LIMIT = RESUME_K_CYCLES + 3;
   logic last_mode;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // supply mode as last written while awake; asleep writes are dropped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         last_mode <= 1'b0;
      end else if (reg_wr && reg_addr == usb_susp_pkg::ADDR_BUS_CTRL2 && !asleep) begin
         last_mode <= reg_wdata[usb_susp_pkg::REGMODE_BIT];
      end
   end

   // steps of a resume and of a sleep entry
   sequence s_line(logic [7:0] v);
      reg_wr && reg_addr == usb_susp_pkg::ADDR_LINE_DRIVE && reg_wdata == v;
   endsequence
   sequence s_sleep_taken;
      sleep_req && !asleep;
   endsequence

   property p_wake_only_asleep;
      wake_irq |-> asleep;
   endproperty
   a_wake_only_asleep: assert property (p_wake_only_asleep)
      else $error("wake request while awake");
   property p_sleep_entry;
      s_sleep_taken |=> asleep;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep request not taken");
   property p_wake_ends;
      asleep && wake_irq |=> !asleep;
   endproperty
   a_wake_ends: assert property (p_wake_ends)
      else $error("wake did not end sleep");
   property p_sleep_holds;
      asleep && !wake_irq |=> asleep;
   endproperty
   a_sleep_holds: assert property (p_sleep_holds)
      else $error("sleep left without wake");
   property p_rdata_stands;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands)
      else $error("read data moved without a read");
   property p_mode_readback;
      reg_rd && reg_addr == usb_susp_pkg::ADDR_BUS_CTRL2 |=> reg_rdata[0] == last_mode;
   endproperty
   a_mode_readback: assert property (p_mode_readback)
      else $error("supply mode bit reads wrong");
   property p_resume_jk;
      s_line(usb_susp_pkg::LINE_J) |=> s_line(usb_susp_pkg::LINE_K) ##1 (!reg_wr) [*8];
   endproperty
   a_resume_jk: assert property (p_resume_jk)
      else $error("J not followed by a held K");
   property p_resume_release;
      s_line(usb_susp_pkg::LINE_K) |-> ##[1:K_LIMIT] s_line(usb_susp_pkg::LINE_RELEASE);
   endproperty
   a_resume_release: assert property (p_resume_release)
      else $error("manual drive not released");
endmodule // usb_susp_chk
`default_nettype wire

// >>> test/usb_suspend_resume_xcvr_ctrl_tb.sv
// bench: firmware end joined to a device end, plus a bench-driven device end
`timescale 1ns/10ps
`default_nettype none
module usb_suspend_resume_xcvr_ctrl_tb;
   localparam int K_CYC = 30;
   logic ref_clk, rst, usb_start, clk48_ready, regulating, set_address, resume_req;
   logic vbus_present, dp_host, dm_host, sie_dp, sie_dm, sie_oe, sie_traffic;
   logic sie_bus_reset, sof_valid;
   logic [6:0] new_address, token_addr;
   logic [10:0] sof_number;
   wire logic busy, suspended;
   wire logic [1:0] dpo, dpe, dmo, dme, am, en, rm, lp, dpi, dmi;
   int miscompares, compares, i, n;
   logic [9:0] ld [5];
   logic [2:0] rx [3];
   usb_ctrl_if bus_if[2] ();

   // a driving end wins the pin, else the host level shows
   assign dpi = (dpe & dpo) | (~dpe & {2{dp_host}});
   assign dmi = (dme & dmo) | (~dme & {2{dm_host}});

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // short counts keep the run brief
   usb_fw_end #(.IDLE_CYCLES(200), .POLL_CYCLES(20), .RESUME_K_CYCLES(K_CYC)) u_usb_fw_end (
      .ref_clk(ref_clk), .rst(rst), .bus(bus_if[0]), .usb_start(usb_start),
      .clk48_ready(clk48_ready), .regulating(regulating), .set_address(set_address),
      .new_address(new_address), .resume_req(resume_req), .vbus_present(vbus_present),
      .sleep_mode_sel(usb_susp_pkg::SLEEP_RETAIN), .busy(busy), .suspended(suspended)
   );

   // device 0 faces the firmware end, device 1 the bench tasks
   for (genvar g = 0; g < 2; g++) begin : g_dev
      usb_dev_end u_usb_dev_end (
         .ref_clk(ref_clk), .rst(rst), .bus(bus_if[g]), .dp_in(dpi[g]), .dp_out(dpo[g]),
         .dp_oe(dpe[g]), .dm_in(dmi[g]), .dm_out(dmo[g]), .dm_oe(dme[g]), .sie_dp(sie_dp),
         .sie_dm(sie_dm), .sie_oe(sie_oe), .sie_traffic(sie_traffic),
         .sie_bus_reset(sie_bus_reset), .sof_valid(sof_valid), .sof_number(sof_number),
         .token_addr(token_addr), .addr_match(am[g]), .usb_enabled(en[g]),
         .regulator_mode(rm[g]), .regulator_low_power(lp[g])
      );
   end

   usb_susp_chk #(.RESUME_K_CYCLES(K_CYC)) u_usb_susp_chk (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(bus_if[0].reg_addr),
      .reg_wdata(bus_if[0].reg_wdata), .reg_wr(bus_if[0].reg_wr), .reg_rd(bus_if[0].reg_rd),
      .reg_rdata(bus_if[0].reg_rdata), .sleep_req(bus_if[0].sleep_req),
      .sleep_mode(bus_if[0].sleep_mode), .asleep(bus_if[0].asleep),
      .wake_irq(bus_if[0].wake_irq)
   );

   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_if[1].reg_addr <= a;
      bus_if[1].reg_wdata <= d;
      bus_if[1].reg_wr <= 1'b1;
      @(posedge ref_clk);
      bus_if[1].reg_wr <= 1'b0;
   endtask

   // read strobe for one cycle, data settled half a cycle later
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus_if[1].reg_addr <= a;
      bus_if[1].reg_rd <= 1'b1;
      @(posedge ref_clk);
      bus_if[1].reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(bus_if[1].reg_rdata, exp);
   endtask

   // requests are lost while busy, so start just after a poll ends
   task automatic sync_fw;
      int k;
      for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge ref_clk);
      for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge ref_clk);
   endtask

   task automatic test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      test_done;
   end

   initial begin
      {usb_start, clk48_ready, regulating, set_address, resume_req, vbus_present} = '0;
      {dp_host, dm_host, sie_dp, sie_dm, sie_oe, sie_traffic, sie_bus_reset, sof_valid} = '0;
      {new_address, token_addr, sof_number} = '0;
      {bus_if[1].reg_addr, bus_if[1].reg_wdata, bus_if[1].reg_wr, bus_if[1].reg_rd} = '0;
      bus_if[1].sleep_req = 1'b0;
      bus_if[1].sleep_mode = usb_susp_pkg::SLEEP_STANDBY;
      // {write value, expected D+, D-}: engine shows SE1, then K, J, SE0, SE0
      ld = '{10'h003, 10'h201, 10'h282, 10'h300, 10'h380};
      rx = '{3'b101, 3'b010, 3'b000};
      rst = 1'b1;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rc(8'h30, 8'h00);
      chk({dpe, dme}, 4'h0);
      rc(8'h31, 8'h00);
      rc(8'h32, 8'h00);
      wr(8'h33, 8'h85);
      rc(8'h33, 8'h85);
      @(posedge ref_clk) token_addr <= 7'h05;
      @(negedge ref_clk) chk(am[1], 1'b1);
      wr(8'h33, 8'h05);
      @(negedge ref_clk) chk({am[1], en[1]}, 2'b00);
      @(posedge ref_clk) sie_bus_reset <= 1'b1;
      @(posedge ref_clk) sie_bus_reset <= 1'b0;
      rc(8'h33, 8'h00);
      wr(8'h33, 8'h80);
      @(posedge ref_clk) sof_number <= 11'h5A3;
      sof_valid <= 1'b1;
      @(posedge ref_clk) sof_valid <= 1'b0;
      wr(8'h31, 8'hFF);
      wr(8'h32, 8'hFF);
      rc(8'h31, 8'hA3);
      rc(8'h32, 8'h05);
      @(posedge ref_clk) {sie_dp, sie_dm, sie_oe} <= 3'b111;
      for (i = 0; i < 5; i++) begin
         wr(8'h34, ld[i][9:2]);
         @(negedge ref_clk) chk({dpo[1], dmo[1], dpe[1], dme[1]}, {ld[i][1:0], 2'b11});
      end
      wr(8'h34, 8'h00);
      @(posedge ref_clk) sie_oe <= 1'b0;
      @(negedge ref_clk) chk({dpe[1], dme[1]}, 2'b00);
      for (i = 0; i < 3; i++) begin
         @(posedge ref_clk) {dp_host, dm_host} <= rx[i][2:1];
         repeat (5) @(posedge ref_clk);
         rc(8'h34, {7'h00, rx[i][0]});
      end
      wr(8'h30, 8'h01);
      rc(8'h30, 8'h01);
      chk(rm[1], 1'b1);
      @(posedge ref_clk) sie_traffic <= 1'b1;
      @(posedge ref_clk) sie_traffic <= 1'b0;
      rc(8'h30, 8'h03);
      rc(8'h30, 8'h03);
      wr(8'h30, 8'h01);
      rc(8'h30, 8'h01);
      // one sleep per mode with D+ high; only the retentive one keeps the frame
      @(posedge ref_clk) {dp_host, dm_host} <= 2'b10;
      repeat (5) @(posedge ref_clk);
      for (i = 0; i < 3; i++) begin
         @(posedge ref_clk) sof_valid <= 1'b1;
         @(posedge ref_clk) sof_valid <= 1'b0;
         bus_if[1].sleep_mode <= usb_susp_pkg::sleep_mode_type'(i[1:0]);
         bus_if[1].sleep_req <= 1'b1;
         @(posedge ref_clk) bus_if[1].sleep_req <= 1'b0;
         @(negedge ref_clk) chk(bus_if[1].asleep, 1'b1);
         chk({lp[1], rm[1], bus_if[1].wake_irq}, 3'b110);
         wr(8'h33, 8'h00);
         @(posedge ref_clk) sie_traffic <= 1'b1;
         @(posedge ref_clk) sie_traffic <= 1'b0;
         @(negedge ref_clk) chk(bus_if[1].asleep, 1'b0);
         rc(8'h31, (i == 1) ? 8'hA3 : 8'h00);
         rc(8'h33, 8'h80);
      end
      @(posedge ref_clk) dp_host <= 1'b0;
      repeat (5) @(posedge ref_clk);
      bus_if[1].sleep_req <= 1'b1;
      @(posedge ref_clk) bus_if[1].sleep_req <= 1'b0;
      @(negedge ref_clk) chk({bus_if[1].asleep, bus_if[1].wake_irq}, 2'b11);
      @(negedge ref_clk) chk(bus_if[1].asleep, 1'b0);
      // firmware end: start refused without the fast clock, then accepted
      @(posedge ref_clk) {dp_host, regulating} <= 2'b11;
      sync_fw;
      @(posedge ref_clk) usb_start <= 1'b1;
      @(posedge ref_clk) usb_start <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(en[0], 1'b0);
      @(posedge ref_clk) clk48_ready <= 1'b1;
      sync_fw;
      @(posedge ref_clk) usb_start <= 1'b1;
      @(posedge ref_clk) usb_start <= 1'b0;
      sync_fw;
      // enable write is still on the port when busy falls
      @(negedge ref_clk) chk({en[0], rm[0]}, 2'b11);
      @(posedge ref_clk) new_address <= 7'h2A;
      @(posedge ref_clk) set_address <= 1'b1;
      @(posedge ref_clk) set_address <= 1'b0;
      token_addr <= 7'h2A;
      sync_fw;
      chk(am[0], 1'b1);
      @(posedge ref_clk) resume_req <= 1'b1;
      @(posedge ref_clk) resume_req <= 1'b0;
      for (n = 0; n < 20 && {dpe[0], dpo[0], dmo[0]} !== 3'b101; n++) @(negedge ref_clk);
      for (n = 0; n < 100 && {dpe[0], dpo[0], dmo[0]} === 3'b101; n++) @(negedge ref_clk);
      chk(n >= K_CYC && n <= K_CYC + 2, 1'b1);
      chk(dpe[0], 1'b0);
      chk(bus_if[0].asleep, 1'b0);
      // idle bus with power present leads to suspend
      @(posedge ref_clk) vbus_present <= 1'b1;
      for (n = 0; n < 800 && bus_if[0].asleep !== 1'b1; n++) @(negedge ref_clk);
      chk({bus_if[0].asleep, suspended}, 2'b11);
      @(posedge ref_clk) sie_traffic <= 1'b1;
      vbus_present <= 1'b0;
      @(posedge ref_clk) sie_traffic <= 1'b0;
      @(negedge ref_clk) chk(bus_if[0].asleep, 1'b0);
      test_done;
   end
endmodule // usb_suspend_resume_xcvr_ctrl_tb
`default_nettype wire

// >>> verilog/pin_filter.sv
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
`default_nettype none
module pin_filter #(
   parameter int W = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } filt_state_type;
   filt_state_type st;
   filt_state_type next_st;

   // first stage feeds only the second; output follows when stages agree
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.q;
endmodule // pin_filter

// >>> verilog/usb_dev_end.sv
// device end: control registers, frame number, sleep and manual line drive
`timescale 1ns/10ps
`default_nettype none
module usb_dev_end (
   input wire logic ref_clk,
   input wire logic rst,
   usb_ctrl_if.device_mp bus,
   input wire logic dp_in,
   output logic dp_out,
   output logic dp_oe,
   input wire logic dm_in,
   output logic dm_out,
   output logic dm_oe,
   input wire logic sie_dp,
   input wire logic sie_dm,
   input wire logic sie_oe,
   input wire logic sie_traffic,
   input wire logic sie_bus_reset,
   input wire logic sof_valid,
   input wire logic [10:0] sof_number,
   input wire logic [6:0] token_addr,
   output logic addr_match,
   output logic usb_enabled,
   output logic regulator_mode,
   output logic regulator_low_power
);
   typedef struct packed {
      logic enable;
      logic [6:0] address;
      logic reg_mode;
      logic activity;
      logic tx_enable;
      logic force_se0;
      logic jk_select;
      logic [10:0] frame;
      logic asleep;
      usb_susp_pkg::sleep_mode_type mode;
      logic [7:0] rdata;
   } dev_state_type;
   dev_state_type st;
   dev_state_type next_st;

   logic [1:0] lines;
   logic rx_diff;
   logic traffic_seen;
   logic wake_cond;

   // pins come from the bus wires, outside this clock
   pin_filter #(
      .W(2)
   ) line_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({dm_in, dp_in}),
      .q(lines)
   );

   // receiver: one only for D+ above D-, zero for SE0 as well
   assign rx_diff = lines[0] & ~lines[1];

   // traffic counts only while the function is switched on
   assign traffic_seen = st.enable & sie_traffic;

   // wake on any traffic or on D+ low, as in K or SE0
   assign wake_cond = sie_traffic | ~lines[0];

   always_comb begin
      next_st = st;

      // register writes; a sleeping device takes none so state holds
      if (bus.reg_wr && !st.asleep) begin
         case (bus.reg_addr)
            usb_susp_pkg::ADDR_BUS_CTRL2: begin
               next_st.reg_mode = bus.reg_wdata[usb_susp_pkg::REGMODE_BIT];
               if (!bus.reg_wdata[usb_susp_pkg::ACTIVITY_BIT]) begin
                  next_st.activity = 1'b0;
               end
            end
            usb_susp_pkg::ADDR_ENABLE_ADDR: begin
               next_st.enable = bus.reg_wdata[usb_susp_pkg::ENABLE_BIT];
               next_st.address = bus.reg_wdata[6:0];
            end
            usb_susp_pkg::ADDR_LINE_DRIVE: begin
               next_st.tx_enable = bus.reg_wdata[usb_susp_pkg::TX_ENABLE_BIT];
               next_st.force_se0 = bus.reg_wdata[usb_susp_pkg::SE0_BIT];
               next_st.jk_select = bus.reg_wdata[usb_susp_pkg::JK_BIT];
            end
            default: begin
               // frame registers are read-only, other offsets unmapped
               next_st.rdata = st.rdata;
            end
         endcase
      end

      // set after the clear, so an event in the clear cycle survives
      if (traffic_seen) begin
         next_st.activity = 1'b1;
      end

      // frame number from each clean start-of-frame packet while enabled and awake
      if (st.enable && sof_valid && !st.asleep) begin
         next_st.frame = sof_number;
      end

      // sleep entry and exit; control registers untouched
      if (!st.asleep) begin
         if (bus.sleep_req) begin
            next_st.asleep = 1'b1;
            next_st.mode = bus.sleep_mode;
         end
      end else if (wake_cond) begin
         next_st.asleep = 1'b0;
         // retentive standby keeps everything
         if (st.mode != usb_susp_pkg::SLEEP_RETAIN) begin
            next_st.frame = usb_susp_pkg::FRAME_RESET;
         end
      end

      // bus reset beats a firmware write in the same cycle
      if (sie_bus_reset) begin
         next_st.enable = usb_susp_pkg::ENABLE_ADDR_RESET[usb_susp_pkg::ENABLE_BIT];
         next_st.address = usb_susp_pkg::ENABLE_ADDR_RESET[6:0];
      end

      // read data is held until the next read strobe
      if (bus.reg_rd) begin
         case (bus.reg_addr)
            usb_susp_pkg::ADDR_BUS_CTRL2: begin
               next_st.rdata = 8'h00;
               next_st.rdata[usb_susp_pkg::REGMODE_BIT] = st.reg_mode;
               next_st.rdata[usb_susp_pkg::ACTIVITY_BIT] = st.activity;
            end
            usb_susp_pkg::ADDR_FRAME_LO: begin
               next_st.rdata = st.frame[7:0];
            end
            usb_susp_pkg::ADDR_FRAME_HI: begin
               next_st.rdata = {5'h00, st.frame[10:8]};
            end
            usb_susp_pkg::ADDR_ENABLE_ADDR: begin
               next_st.rdata = {st.enable, st.address};
            end
            usb_susp_pkg::ADDR_LINE_DRIVE: begin
               next_st.rdata = 8'h00;
               next_st.rdata[usb_susp_pkg::TX_ENABLE_BIT] = st.tx_enable;
               next_st.rdata[usb_susp_pkg::SE0_BIT] = st.force_se0;
               next_st.rdata[usb_susp_pkg::JK_BIT] = st.jk_select;
               next_st.rdata[usb_susp_pkg::RX_BIT] = rx_diff;
            end
            default: begin
               next_st.rdata = usb_susp_pkg::READ_UNMAPPED;
            end
         endcase
      end
   end

   // reset values; regulator comes up in pass-through
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st.enable <= usb_susp_pkg::ENABLE_ADDR_RESET[usb_susp_pkg::ENABLE_BIT];
         st.address <= usb_susp_pkg::ENABLE_ADDR_RESET[6:0];
         st.reg_mode <= usb_susp_pkg::BUS_CTRL2_RESET[usb_susp_pkg::REGMODE_BIT];
         st.activity <= usb_susp_pkg::BUS_CTRL2_RESET[usb_susp_pkg::ACTIVITY_BIT];
         st.tx_enable <= usb_susp_pkg::LINE_DRIVE_RESET[usb_susp_pkg::TX_ENABLE_BIT];
         st.force_se0 <= usb_susp_pkg::LINE_DRIVE_RESET[usb_susp_pkg::SE0_BIT];
         st.jk_select <= usb_susp_pkg::LINE_DRIVE_RESET[usb_susp_pkg::JK_BIT];
         st.frame <= usb_susp_pkg::FRAME_RESET;
         st.asleep <= 1'b0;
         st.mode <= usb_susp_pkg::SLEEP_STANDBY;
         st.rdata <= usb_susp_pkg::READ_UNMAPPED;
      end else begin
         st <= next_st;
      end
   end

   // line drive: manual beats engine; nothing driven after reset
   always_comb begin
      dp_out = 1'b0;
      dm_out = 1'b0;
      dp_oe = 1'b0;
      dm_oe = 1'b0;
      if (st.tx_enable) begin
         dp_oe = 1'b1;
         dm_oe = 1'b1;
         if (st.force_se0) begin
            dp_out = 1'b0;
            dm_out = 1'b0;
         end else begin
            dp_out = st.jk_select;
            dm_out = ~st.jk_select;
         end
      end else if (st.enable && sie_oe) begin
         // engine owns the lines only when switched on
         dp_out = sie_dp;
         dm_out = sie_dm;
         dp_oe = 1'b1;
         dm_oe = 1'b1;
      end
   end

   // engine answers only its own address while enabled
   assign addr_match = st.enable & (token_addr == st.address);
   assign usb_enabled = st.enable;
   assign regulator_mode = st.reg_mode;
   // regulator low power follows sleep alone, mode kept
   assign regulator_low_power = st.asleep;
   assign bus.asleep = st.asleep;
   assign bus.wake_irq = st.asleep & wake_cond;
   assign bus.reg_rdata = st.rdata;
endmodule // usb_dev_end

// >>> verilog/usb_fw_end.sv
// firmware end: enable, address, activity polling, suspend and resume
`timescale 1ns/10ps
`default_nettype none
module usb_fw_end #(
   parameter int unsigned IDLE_CYCLES = usb_susp_pkg::IDLE_CYCLES,
   parameter int unsigned POLL_CYCLES = usb_susp_pkg::POLL_CYCLES,
   parameter int unsigned RESUME_K_CYCLES = usb_susp_pkg::RESUME_K_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   usb_ctrl_if.firmware_mp bus,
   input wire logic usb_start,
   input wire logic clk48_ready,
   input wire logic regulating,
   input wire logic set_address,
   input wire logic [6:0] new_address,
   input wire logic resume_req,
   input wire logic vbus_present,
   input wire usb_susp_pkg::sleep_mode_type sleep_mode_sel,
   output logic busy,
   output logic suspended
);
   typedef enum logic [3:0] {
      FW_IDLE = 4'b0000,
      FW_ENABLE = 4'b0001,
      FW_RES_K = 4'b0010,
      FW_RES_HOLD = 4'b0011,
      FW_POLL_WAIT = 4'b0100,
      FW_POLL_CHECK = 4'b0101,
      FW_SLEEP_REQ = 4'b0110,
      FW_SLEEP_WAIT = 4'b0111
   } fw_phase_type;

   typedef struct packed {
      fw_phase_type phase;
      logic [23:0] idle_cnt;
      logic [23:0] poll_cnt;
      logic [23:0] timer;
      logic reg_mode;
      logic [7:0] reg_addr;
      logic [7:0] reg_wdata;
      logic reg_wr;
      logic reg_rd;
      logic sleep_req;
      usb_susp_pkg::sleep_mode_type sleep_mode;
   } fw_state_type;
   fw_state_type st;
   fw_state_type next_st;

   // sequencer; register strobes last one cycle each
   always_comb begin
      next_st = st;
      next_st.reg_wr = 1'b0;
      next_st.reg_rd = 1'b0;
      next_st.sleep_req = 1'b0;
      if (st.idle_cnt != 24'hFFFFFF) begin
         next_st.idle_cnt = st.idle_cnt + 24'h000001;
      end
      case (st.phase)
         FW_IDLE: begin
            next_st.poll_cnt = st.poll_cnt + 24'h000001;
            if (usb_start && clk48_ready) begin
               // supply mode chosen once, never touched around sleep
               next_st.reg_mode = regulating;
               next_st.reg_wr = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_BUS_CTRL2;
               next_st.reg_wdata = {7'h00, regulating};
               next_st.phase = FW_ENABLE;
            end else if (set_address) begin
               next_st.reg_wr = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_ENABLE_ADDR;
               next_st.reg_wdata = {1'b1, new_address};
            end else if (resume_req) begin
               next_st.reg_wr = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_LINE_DRIVE;
               next_st.reg_wdata = usb_susp_pkg::LINE_J;
               next_st.phase = FW_RES_K;
            end else if (st.poll_cnt >= 24'(POLL_CYCLES - 1)) begin
               next_st.poll_cnt = 24'h000000;
               next_st.reg_rd = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_BUS_CTRL2;
               next_st.phase = FW_POLL_WAIT;
            end
         end
         FW_ENABLE: begin
            next_st.reg_wr = 1'b1;
            next_st.reg_addr = usb_susp_pkg::ADDR_ENABLE_ADDR;
            next_st.reg_wdata = usb_susp_pkg::ENABLE_ONLY;
            next_st.phase = FW_IDLE;
         end
         FW_RES_K: begin
            // J stood for exactly one step before this
            next_st.reg_wr = 1'b1;
            next_st.reg_addr = usb_susp_pkg::ADDR_LINE_DRIVE;
            next_st.reg_wdata = usb_susp_pkg::LINE_K;
            next_st.timer = 24'(RESUME_K_CYCLES - 1);
            next_st.phase = FW_RES_HOLD;
         end
         FW_RES_HOLD: begin
            if (st.timer == 24'h000000) begin
               next_st.reg_wr = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_LINE_DRIVE;
               next_st.reg_wdata = usb_susp_pkg::LINE_RELEASE;
               next_st.phase = FW_IDLE;
            end else begin
               next_st.timer = st.timer - 24'h000001;
            end
         end
         FW_POLL_WAIT: begin
            next_st.phase = FW_POLL_CHECK;
         end
         FW_POLL_CHECK: begin
            next_st.phase = FW_IDLE;
            if (bus.reg_rdata[usb_susp_pkg::ACTIVITY_BIT]) begin
               // clear the flag, keep the supply bit as it was
               next_st.idle_cnt = 24'h000000;
               next_st.reg_wr = 1'b1;
               next_st.reg_addr = usb_susp_pkg::ADDR_BUS_CTRL2;
               next_st.reg_wdata = {7'h00, st.reg_mode};
            end else if (vbus_present && st.idle_cnt >= 24'(IDLE_CYCLES)) begin
               next_st.sleep_req = 1'b1;
               next_st.sleep_mode = sleep_mode_sel;
               next_st.phase = FW_SLEEP_REQ;
            end
         end
         FW_SLEEP_REQ: begin
            next_st.phase = FW_SLEEP_WAIT;
         end
         FW_SLEEP_WAIT: begin
            if (!bus.asleep) begin
               next_st.idle_cnt = 24'h000000;
               next_st.poll_cnt = 24'h000000;
               next_st.phase = FW_IDLE;
            end
         end
         default: begin
            next_st.phase = FW_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // the bit-bang register is addressed here only for the J, K and release writes of a resume
   assign bus.reg_addr = st.reg_addr;
   assign bus.reg_wdata = st.reg_wdata;
   assign bus.reg_wr = st.reg_wr;
   assign bus.reg_rd = st.reg_rd;
   assign bus.sleep_req = st.sleep_req;
   assign bus.sleep_mode = st.sleep_mode;
   assign busy = (st.phase != FW_IDLE);
   assign suspended = (st.phase == FW_SLEEP_WAIT);
endmodule // usb_fw_end
